/* dual_gpio_analog_shared_port.sv */
`timescale 1ns/1ps
// Contract
// - Two ports, eight pins each, one bit per pin in every register.
// - After reset every pin floats with digital input disabled for analog use.
// - Reset sets every output latch bit to one.
// - Data read returns pin levels, zero where direction and enable are both 0; data write loads the output latch.
// - Direction bit 0 is input, 1 is output; clears at reset.
// - Input-enable bit 0 disables, 1 enables digital input; clears at reset.
// - Bit x of direction and enable governs pin x of that port only.
// - Direction 1 means output whatever enable says; else enable decides.
// - Port logic never picks the converter channel; converter mode does.
module dual_gpio_analog_shared_port #(
  parameter int W = gpio_pkg::PORT_W
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic [gpio_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic [W-1:0]              first_pin_in,
  output logic      [W-1:0]              first_pin_out,
  output logic      [W-1:0]              first_pin_oe_n,
  output logic      [W-1:0]              first_pin_in_en,
  input  wire logic [W-1:0]              second_pin_in,
  output logic      [W-1:0]              second_pin_out,
  output logic      [W-1:0]              second_pin_oe_n,
  output logic      [W-1:0]              second_pin_in_en
);
  gpio_pkg::bus_req_type  req;
  gpio_pkg::port_cfg_type cfg_a;
  gpio_pkg::port_cfg_type cfg_b;
  logic [W-1:0] lvl_a;
  logic [W-1:0] lvl_b;
  logic         hit_a;
  logic         hit_b;
  logic [W-1:0] rv_a;
  logic [W-1:0] rv_b;
  logic [7:0]   rdata_nxt;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  pin_sync #(.W(W)) u_sync_a (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .pin_async    (first_pin_in),
    .pin_sync_out (lvl_a)
  );

  pin_sync #(.W(W)) u_sync_b (
    .clk_sys      (clk_sys),
    .arst_n       (arst_n),
    .pin_async    (second_pin_in),
    .pin_sync_out (lvl_b)
  );

  gpio_port #(
    .W        (W),
    .DATA_OFS (gpio_pkg::FIRST_PORT_PIN_DATA_OFS),
    .DIR_OFS  (gpio_pkg::FIRST_PORT_DIRECTION_OFS),
    .INEN_OFS (gpio_pkg::FIRST_PORT_INPUT_ENABLE_OFS)
  ) u_port_a (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .req       (req),
    .pin_level (lvl_a),
    .hit       (hit_a),
    .rd_value  (rv_a),
    .cfg       (cfg_a)
  );

  gpio_port #(
    .W        (W),
    .DATA_OFS (gpio_pkg::SECOND_PORT_PIN_DATA_OFS),
    .DIR_OFS  (gpio_pkg::SECOND_PORT_DIRECTION_OFS),
    .INEN_OFS (gpio_pkg::SECOND_PORT_INPUT_ENABLE_OFS)
  ) u_port_b (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .req       (req),
    .pin_level (lvl_b),
    .hit       (hit_b),
    .rd_value  (rv_b),
    .cfg       (cfg_b)
  );

  // Unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit_a) rdata_nxt = rv_a;
    else if (hit_b) rdata_nxt = rv_b;
  end

  // read data one cycle after strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // pins float, inputs off after reset
  // no converter channel choice here
  // Registered pin controls trail the register write by one cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      first_pin_out    <= gpio_pkg::LATCH_RST;
      first_pin_oe_n   <= '1;
      first_pin_in_en  <= '0;
      second_pin_out   <= gpio_pkg::LATCH_RST;
      second_pin_oe_n  <= '1;
      second_pin_in_en <= '0;
    end else begin
      first_pin_out    <= cfg_a.latch;
      first_pin_oe_n   <= ~cfg_a.direction;
      first_pin_in_en  <= ~cfg_a.direction & cfg_a.in_enable;
      second_pin_out   <= cfg_b.latch;
      second_pin_oe_n  <= ~cfg_b.direction;
      second_pin_in_en <= ~cfg_b.direction & cfg_b.in_enable;
    end
  end

  // software writes whole values; write-only control reads zero

  logic [W-1:0] dir_d;
  logic [W-1:0] inen_d;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dir_d  <= '0;
      inen_d <= '0;
    end else begin
      dir_d  <= cfg_a.direction;
      inen_d <= cfg_a.in_enable;
    end
  end

  a_latch_reset_ones: assert property (@(posedge clk_sys)
    $rose(arst_n) |-> first_pin_out == 8'hFF && second_pin_out == 8'hFF)
    else $error("latch not all ones after reset");

  a_reset_floats: assert property (@(posedge clk_sys)
    $rose(arst_n) |-> &first_pin_oe_n && &second_pin_oe_n && first_pin_in_en == 8'h00)
    else $error("pins not floating after reset");

  a_dir_write_drives: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && reg_addr == 8'h16 |=> ##1 first_pin_oe_n == ~$past(reg_wdata, 2))
    else $error("direction write did not reach pin enable");

  a_data_write_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && reg_addr == 8'h18 |=> ##1 second_pin_out == $past(reg_wdata, 2))
    else $error("data write did not reach latch");

  a_output_over_enable: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (first_pin_in_en & ~first_pin_oe_n) == 8'h00)
    else $error("input enabled on output pin");

  a_enable_per_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 first_pin_in_en == (~dir_d & inen_d))
    else $error("input enable not bitwise");

  a_read_one_cycle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  a_disabled_reads_fixed: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && reg_addr == 8'h14 && cfg_a.direction == 8'h00 && cfg_a.in_enable == 8'h00
    |=> reg_rdata == 8'h00)
    else $error("disabled input read floating level");

  a_inen_reset_zero: assert property (@(posedge clk_sys)
    $rose(arst_n) |-> second_pin_in_en == 8'h00 && cfg_b.in_enable == 8'h00)
    else $error("input enable not cleared");

  a_rdata_reset_zero: assert property (@(posedge clk_sys)
    $rose(arst_n) |-> reg_rdata == 8'h00)
    else $error("read data not zero after reset");

  a_second_dir_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && reg_addr == gpio_pkg::SECOND_PORT_DIRECTION_OFS
    |=> ##1 second_pin_oe_n == ~$past(reg_wdata, 2))
    else $error("second direction write did not reach pin enable");

  a_first_data_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && reg_addr == gpio_pkg::FIRST_PORT_PIN_DATA_OFS
    |=> ##1 first_pin_out == $past(reg_wdata, 2))
    else $error("first data write did not reach latch");

  a_second_over_enable: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (second_pin_in_en & ~second_pin_oe_n) == 8'h00)
    else $error("input enabled on second port output pin");

  a_first_inen_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && reg_addr == gpio_pkg::FIRST_PORT_INPUT_ENABLE_OFS
    |=> cfg_a.in_enable == $past(reg_wdata))
    else $error("first input enable write lost");

  a_second_inen_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && reg_addr == gpio_pkg::SECOND_PORT_INPUT_ENABLE_OFS
    |=> cfg_b.in_enable == $past(reg_wdata))
    else $error("second input enable write lost");

  // Write-only control must never leak onto the read bus
  a_ctrl_reads_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && (reg_addr == gpio_pkg::FIRST_PORT_DIRECTION_OFS ||
               reg_addr == gpio_pkg::FIRST_PORT_INPUT_ENABLE_OFS ||
               reg_addr == gpio_pkg::SECOND_PORT_DIRECTION_OFS ||
               reg_addr == gpio_pkg::SECOND_PORT_INPUT_ENABLE_OFS)
    |=> reg_rdata == 8'h00)
    else $error("write-only register read not zero");

  a_unmapped_ignored: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && !hit_a && !hit_b |=> $stable(cfg_a) && $stable(cfg_b))
    else $error("unmapped write changed a port");

  a_ports_separate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && hit_a |=> $stable(cfg_b))
    else $error("first port write disturbed second port");

  a_second_reads_fixed: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && reg_addr == gpio_pkg::SECOND_PORT_PIN_DATA_OFS &&
    cfg_b.direction == 8'h00 && cfg_b.in_enable == 8'h00
    |=> reg_rdata == gpio_pkg::DISABLED_READ)
    else $error("second port disabled input read floating level");

  // Driven pins read back the synchronised pad level
  a_pin_levels_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && reg_addr == gpio_pkg::FIRST_PORT_PIN_DATA_OFS && cfg_a.direction == 8'hFF
    |=> reg_rdata == $past(lvl_a))
    else $error("data read did not return pin levels");

  c_dir_write: cover property (@(posedge clk_sys) reg_wr && reg_addr == 8'h1A);
  c_second_output: cover property (@(posedge clk_sys) second_pin_oe_n != 8'hFF);
  c_second_read: cover property (@(posedge clk_sys) reg_rd && reg_addr == 8'h18);
  c_data_read: cover property (@(posedge clk_sys) reg_rd && reg_addr == 8'h14);
  c_input_enabled: cover property (@(posedge clk_sys) first_pin_in_en != 8'h00);
endmodule

/* dual_gpio_analog_shared_port_test.sv */
`timescale 1ns/1ps
module dual_gpio_analog_shared_port_test;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] pin_in [2];
  logic [7:0] pin_out [2];
  logic [7:0] oe_n [2];
  logic [7:0] in_en [2];
  logic [7:0] ext [2] = '{8'hA5, 8'h3C};
  int         n_fail = 0;
  int         samples_checked = 0;
  localparam logic [7:0] BASE [2] = '{8'h14, 8'h18};

  always #10 clk_sys = ~clk_sys;

  dual_gpio_analog_shared_port u_dut (
    .clk_sys          (clk_sys),
    .arst_n           (arst_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .first_pin_in     (pin_in[0]),
    .first_pin_out    (pin_out[0]),
    .first_pin_oe_n   (oe_n[0]),
    .first_pin_in_en  (in_en[0]),
    .second_pin_in    (pin_in[1]),
    .second_pin_out   (pin_out[1]),
    .second_pin_oe_n  (oe_n[1]),
    .second_pin_in_en (in_en[1])
  );

  for (genvar g = 0; g < 2; g++) begin : g_pad
    pin_model u_pads (
      .pad_out   (pin_out[g]),
      .pad_oe_n  (oe_n[g]),
      .world     (ext[g]),
      .pad_level (pin_in[g])
    );
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Always whole-byte writes, never read-modify-write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic t_reset(input int n);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    for (int p = 0; p < 2; p++) begin
      chk(pin_out[p], 8'hFF);
      chk(oe_n[p], 8'hFF);
      chk(in_en[p], 8'h00);
      rd(BASE[p] + 8'h02, 8'h00);
      repeat (4) @(posedge clk_sys);
      rd(BASE[p], 8'h00);
    end
    $display("reset test done");
  endtask

  task automatic t_inen(input int p);
    wr(BASE[p] + 8'h03, 8'h0F);
    chk(in_en[p], 8'h0F);
    chk(oe_n[p], 8'hFF);
    repeat (4) @(posedge clk_sys);
    rd(BASE[p], ext[p] & 8'h0F);
    $display("input enable test done, port %0d", p);
  endtask

  task automatic t_dir(input int p);
    wr(BASE[p] + 8'h02, 8'h81);
    chk(oe_n[p], 8'h7E);
    chk(in_en[p], 8'h0E);
    chk(oe_n[1-p], p ? 8'h7E : 8'hFF);
    wr(BASE[p], 8'h5A);
    chk(pin_out[p], 8'h5A);
    repeat (4) @(posedge clk_sys);
    rd(BASE[p], (8'h5A & 8'h81) | (ext[p] & 8'h0E));
    $display("direction test done, port %0d", p);
  endtask

  task automatic t_unmapped;
    wr(8'h15, 8'h00);
    wr(8'h19, 8'h00);
    rd(8'h15, 8'h00);
    chk(oe_n[0], 8'h7E);
    chk(pin_out[1], 8'h5A);
    $display("unmapped test done");
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is about a hundred cycles
  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end

  initial begin
    t_reset(12);
    for (int p = 0; p < 2; p++) begin
      t_inen(p);
      t_dir(p);
    end
    t_unmapped();
    t_reset(3);
    print_verdict();
  end
endmodule

/* gpio_pkg.sv */
package gpio_pkg;

  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;

  // Register offsets
  localparam logic [7:0] FIRST_PORT_PIN_DATA_OFS       = 8'h14;
  localparam logic [7:0] FIRST_PORT_DIRECTION_OFS      = 8'h16;
  localparam logic [7:0] FIRST_PORT_INPUT_ENABLE_OFS   = 8'h17;
  localparam logic [7:0] SECOND_PORT_PIN_DATA_OFS      = 8'h18;
  localparam logic [7:0] SECOND_PORT_DIRECTION_OFS     = 8'h1A;
  localparam logic [7:0] SECOND_PORT_INPUT_ENABLE_OFS  = 8'h1B;

  // Reset values
  localparam logic [7:0] LATCH_RST     = 8'hFF;
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [7:0] IN_ENABLE_RST = 8'h00;
  // Read value of a pin whose direction and input enable bits are both 0
  localparam logic [7:0] DISABLED_READ = 8'h00;

  // Register select within one port
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_DATA,
    SEL_DIR,
    SEL_INEN
  } reg_sel_type;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] direction;
    logic [7:0] in_enable;
  } port_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

endpackage

/* gpio_port.sv */
`timescale 1ns/1ps
// One 8-bit port: latch, direction and input enable, with pin data read
module gpio_port #(
  parameter int W = 8,
  parameter logic [7:0] DATA_OFS = 8'h14,
  parameter logic [7:0] DIR_OFS  = 8'h16,
  parameter logic [7:0] INEN_OFS = 8'h17
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire gpio_pkg::bus_req_type req,
  input  wire logic [W-1:0] pin_level,
  output logic              hit,
  output logic      [W-1:0] rd_value,
  output gpio_pkg::port_cfg_type cfg
);
  gpio_pkg::reg_sel_type sel;
  logic [W-1:0] latch_r;
  logic [W-1:0] direction_r;
  logic [W-1:0] in_enable_r;

  function automatic gpio_pkg::reg_sel_type decode(input logic [7:0] a);
    if (a == DATA_OFS) decode = gpio_pkg::SEL_DATA;
    else if (a == DIR_OFS) decode = gpio_pkg::SEL_DIR;
    else if (a == INEN_OFS) decode = gpio_pkg::SEL_INEN;
    else decode = gpio_pkg::SEL_NONE;
  endfunction

  assign sel = decode(req.addr);
  assign hit = (sel != gpio_pkg::SEL_NONE);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= gpio_pkg::LATCH_RST;
    end else if (req.wr && sel == gpio_pkg::SEL_DATA) begin
      latch_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      direction_r <= gpio_pkg::DIRECTION_RST;
    end else if (req.wr && sel == gpio_pkg::SEL_DIR) begin
      direction_r <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_enable_r <= gpio_pkg::IN_ENABLE_RST;
    end else if (req.wr && sel == gpio_pkg::SEL_INEN) begin
      in_enable_r <= req.wdata;
    end
  end

  always_comb begin
    rd_value = '0;
    if (sel == gpio_pkg::SEL_DATA) begin
      for (int i = 0; i < W; i++) begin
        if (direction_r[i] || in_enable_r[i]) rd_value[i] = pin_level[i];
        else rd_value[i] = gpio_pkg::DISABLED_READ[i];
      end
    end
  end

  // Control registers are write-only and read as zero
  assign cfg.latch     = latch_r;
  assign cfg.direction = direction_r;
  assign cfg.in_enable = in_enable_r;
endmodule

/* pin_model.sv */
`timescale 1ns/1ps
// Pads of one port; an undriven pad shows what the outside world puts on it
module pin_model (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] world,
  output logic      [7:0] pad_level
);
  assign pad_level = (pad_out & ~pad_oe_n) | (world & pad_oe_n);
endmodule

/* pin_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a pin bus
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] pin_sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
    end
  end

  assign pin_sync_out = sync_r;
endmodule
